// >>> hdl/scs_pkg.sv
// Operation
// RQ1: enable strap up to 180k enables autosleep
// RQ2: enable strap sets entry duty, lowers current
// RQ3: threshold strap sets exit duty, source off
// RQ4: 100k enable: entry 40, exit 80/75/65/60
// RQ5: 180k enable: entry 25, exit 75/70/60/55
// RQ6: open enable strap latches autosleep disabled
// RQ7: sleep disabled: low duty never enters sleep
// RQ8: sleep disabled: halt or off command sleeps
// RQ9: resume only when duty exceeds exit threshold
// RQ10: disabled burst exit 80/75/65/0 percent
// RQ11: entry condition must hold 512 cycles
// RQ12: burst when both senses armed 20 us
// RQ13: wait 24 clock cycles before driving again
// RQ14: enable rising edge repeats strap phase
// RQ15: strap codes latched until next strap phase
// RQ16: undefined enable code maps to nearest defined
package scs_pkg;
    // enable strap level codes from the measuring stage
    localparam logic [1:0] EN_CODE_100K = 2'h0;
    localparam logic [1:0] EN_CODE_180K = 2'h1;
    localparam logic [1:0] EN_CODE_OPEN = 2'h2;
    // threshold strap codes: zero ohm, 100k, 180k, open
    localparam logic [1:0] TH_CODE_ZERO = 2'h0;
    localparam logic [1:0] TH_CODE_OPEN = 2'h3;
    // duties in percent
    localparam logic [6:0] ENTRY_DUTY_100K = 7'h28; // 40
    localparam logic [6:0] ENTRY_DUTY_180K = 7'h19; // 25
    localparam logic [6:0] EXIT_100K_0 = 7'h50; // 80
    localparam logic [6:0] EXIT_100K_1 = 7'h4B; // 75
    localparam logic [6:0] EXIT_100K_2 = 7'h41; // 65
    localparam logic [6:0] EXIT_100K_3 = 7'h3C; // 60
    localparam logic [6:0] EXIT_180K_0 = 7'h4B; // 75
    localparam logic [6:0] EXIT_180K_1 = 7'h46; // 70
    localparam logic [6:0] EXIT_180K_2 = 7'h3C; // 60
    localparam logic [6:0] EXIT_180K_3 = 7'h37; // 55
    localparam logic [6:0] BURST_EXIT_0 = 7'h50; // 80
    localparam logic [6:0] BURST_EXIT_1 = 7'h4B; // 75
    localparam logic [6:0] BURST_EXIT_2 = 7'h41; // 65
    localparam logic [6:0] BURST_EXIT_3 = 7'h00; // 0
    // timing
    localparam int CLK_MHZ = 250;
    localparam int BURST_TIME_US = 20;
    localparam int BURST_CYCLES = BURST_TIME_US * CLK_MHZ;
    localparam int SLEEP_CONFIRM_CYCLES = 512;
    localparam int RESUME_CYCLES = 24;
    // register map (byte addresses)
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
    // operating states
    typedef enum logic [3:0] {
        ST_STRAP = 4'b0001,
        ST_RUN = 4'b0010,
        ST_LOWPOW = 4'b0100,
        ST_RESUME = 4'b1000
    } scs_state_type;
endpackage : scs_pkg

// >>> hdl/scs_top.sv
`timescale 1ns/1ns
module scs_top #(
    parameter int BURST_CYCLES_P = scs_pkg::BURST_CYCLES
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic enable_pin_i, // enable pin above on-threshold (async)
    input wire logic [1:0] enable_strap_code_i, // async level code
    input wire logic [1:0] threshold_strap_code_i, // async level code
    input wire logic drain_sense_one_i, // above arming_level (async)
    input wire logic drain_sense_two_i, // above arming_level (async)
    input wire logic [6:0] duty_i, // measured conduction duty percent, same domain
    input wire logic duty_valid_i, // one pulse per switching cycle
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic gate_enable_o, // rectifier drive allowed
    output logic low_power_o,
    output logic enable_current_low_o, // enable pin source at running value
    output logic threshold_strap_current_o, // threshold strap source on
    output logic irq_o
);
    // whole state in one struct
    typedef struct packed {
        logic [1:0] en_s1, en_s2, en_prev;
        logic [1:0] ens_s1, ens_s2;
        logic [1:0] ths_s1, ths_s2;
        logic [1:0] ds_s1, ds_s2;
        scs_pkg::scs_state_type st;
        logic sleep_en;
        logic [6:0] entry_duty;
        logic [6:0] exit_duty;
        logic [12:0] burst_cnt;
        logic [9:0] conf_cnt;
        logic [4:0] res_cnt;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic [31:0] rdata;
        logic ack;
        logic gate;
        logic lowp;
        logic en_cur_low;
        logic th_cur;
        logic irq;
    } scs_regs_type;

    scs_regs_type r_q, r_d;

    // synchronised views; only second stage and en_prev are read by logic
    logic en_now;
    logic armed;
    logic en_rise;
    logic wb_hit;
    logic [2:0] ev;
    logic [6:0] exit_sel;
    logic [6:0] entry_sel;
    logic [1:0] en_code;
    assign en_now = r_q.en_s2[0];
    assign armed = &r_q.ds_s2;
    assign en_rise = r_q.en_s2[0] & ~r_q.en_prev[0];
    assign wb_hit = wb_cyc_i & wb_stb_i & ~r_q.ack;

    // strap decode; undefined enable code 3 treated as open (nearest) [RQ16]
    always_comb
    begin
        // only the synchronised code is read; the raw pin may be mid-change
        en_code = r_q.ens_s2;
        if (r_q.ens_s2 == 2'h3)
        begin
            en_code = scs_pkg::EN_CODE_OPEN;
        end
        entry_sel = (en_code == scs_pkg::EN_CODE_180K) ? scs_pkg::ENTRY_DUTY_180K
                                                       : scs_pkg::ENTRY_DUTY_100K; // [RQ2]
        exit_sel = scs_pkg::BURST_EXIT_0;
        unique case ({en_code == scs_pkg::EN_CODE_OPEN, en_code == scs_pkg::EN_CODE_180K, r_q.ths_s2})
            4'h0: exit_sel = scs_pkg::EXIT_100K_0; // [RQ4]
            4'h1: exit_sel = scs_pkg::EXIT_100K_1;
            4'h2: exit_sel = scs_pkg::EXIT_100K_2;
            4'h3: exit_sel = scs_pkg::EXIT_100K_3;
            4'h4: exit_sel = scs_pkg::EXIT_180K_0; // [RQ5]
            4'h5: exit_sel = scs_pkg::EXIT_180K_1;
            4'h6: exit_sel = scs_pkg::EXIT_180K_2;
            4'h7: exit_sel = scs_pkg::EXIT_180K_3;
            4'h8: exit_sel = scs_pkg::BURST_EXIT_0; // [RQ10]
            4'h9: exit_sel = scs_pkg::BURST_EXIT_1;
            4'hA: exit_sel = scs_pkg::BURST_EXIT_2;
            4'hB: exit_sel = scs_pkg::BURST_EXIT_3;
            default: exit_sel = scs_pkg::BURST_EXIT_0;
        endcase
    end

    // next-state logic
    always_comb
    begin
        r_d = r_q;
        ev = 3'h0;
        // two-flop synchronisers for pin levels
        r_d.en_s1 = {1'b0, enable_pin_i};
        r_d.en_s2 = r_q.en_s1;
        r_d.en_prev = r_q.en_s2;
        r_d.ens_s1 = enable_strap_code_i;
        r_d.ens_s2 = r_q.ens_s1;
        r_d.ths_s1 = threshold_strap_code_i;
        r_d.ths_s2 = r_q.ths_s1;
        r_d.ds_s1 = {drain_sense_two_i, drain_sense_one_i};
        r_d.ds_s2 = r_q.ds_s1;
        // burst detector: both senses armed long enough [RQ12]
        if (!armed)
        begin
            r_d.burst_cnt = 13'h0;
        end
        else if (r_q.burst_cnt < 13'(BURST_CYCLES_P))
        begin
            r_d.burst_cnt = r_q.burst_cnt + 13'h1;
        end
        unique case (r_q.st)
            scs_pkg::ST_STRAP:
            begin
                // latch configuration once enable is high [RQ15]
                if (en_now)
                begin
                    r_d.sleep_en = (en_code != scs_pkg::EN_CODE_OPEN); // [RQ1] [RQ6]
                    r_d.entry_duty = entry_sel; // [RQ2]
                    r_d.exit_duty = exit_sel; // [RQ3]
                    r_d.en_cur_low = 1'b1; // [RQ2]
                    r_d.th_cur = 1'b0; // [RQ3]
                    r_d.conf_cnt = 10'h0;
                    r_d.st = scs_pkg::ST_RUN;
                end
            end
            scs_pkg::ST_RUN:
            begin
                // count consecutive low-duty cycles only when sleep allowed [RQ7]
                if (duty_valid_i)
                begin
                    if (r_q.sleep_en && duty_i < r_q.entry_duty)
                    begin
                        r_d.conf_cnt = r_q.conf_cnt + 10'h1;
                    end
                    else
                    begin
                        r_d.conf_cnt = 10'h0;
                    end
                end
                if (!en_now || r_q.burst_cnt >= 13'(BURST_CYCLES_P)) // [RQ8]
                begin
                    r_d.st = scs_pkg::ST_LOWPOW;
                    ev[0] = 1'b1;
                end
                else if (r_q.conf_cnt >= 10'(scs_pkg::SLEEP_CONFIRM_CYCLES)) // [RQ11]
                begin
                    r_d.st = scs_pkg::ST_LOWPOW;
                    ev[0] = 1'b1;
                end
            end
            scs_pkg::ST_LOWPOW:
            begin
                r_d.conf_cnt = 10'h0;
                if (en_now && !armed && duty_valid_i && duty_i > r_q.exit_duty) // [RQ9]
                begin
                    r_d.res_cnt = 5'h0;
                    r_d.st = scs_pkg::ST_RESUME;
                end
            end
            scs_pkg::ST_RESUME:
            begin
                if (!en_now || r_q.burst_cnt >= 13'(BURST_CYCLES_P))
                begin
                    r_d.st = scs_pkg::ST_LOWPOW;
                end
                else if (r_q.res_cnt == 5'(scs_pkg::RESUME_CYCLES - 1)) // [RQ13]
                begin
                    r_d.st = scs_pkg::ST_RUN;
                    ev[1] = 1'b1;
                end
                else
                begin
                    r_d.res_cnt = r_q.res_cnt + 5'h1;
                end
            end
            default: r_d.st = scs_pkg::ST_STRAP;
        endcase
        // enable rising edge restarts strap phase [RQ14]
        if (en_rise && r_q.st != scs_pkg::ST_STRAP)
        begin
            r_d.st = scs_pkg::ST_STRAP;
            r_d.en_cur_low = 1'b0;
            r_d.th_cur = 1'b1;
        end
        if (en_rise)
        begin
            ev[2] = 1'b1;
        end
        r_d.gate = (r_d.st == scs_pkg::ST_RUN);
        r_d.lowp = (r_d.st == scs_pkg::ST_LOWPOW) || (r_d.st == scs_pkg::ST_RESUME);
        // wishbone slave: one wait, ack for one cycle
        r_d.ack = wb_hit;
        r_d.rdata = 32'h0;
        if (wb_hit && !wb_we_i)
        begin
            unique case (wb_adr_i)
                scs_pkg::ADDR_CTRL: r_d.rdata = {25'h0, r_q.exit_duty};
                scs_pkg::ADDR_STATUS: r_d.rdata = {8'h0, 1'b0, r_q.entry_duty, 11'h0, r_q.sleep_en, r_q.st};
                scs_pkg::ADDR_IRQ_STAT: r_d.rdata = {29'h0, r_q.irq_stat};
                scs_pkg::ADDR_IRQ_MASK: r_d.rdata = {29'h0, r_q.irq_mask};
                default: r_d.rdata = 32'h0;
            endcase
        end
        if (wb_hit && wb_we_i && wb_adr_i == scs_pkg::ADDR_IRQ_MASK && wb_sel_i[0])
        begin
            r_d.irq_mask = wb_dat_i[2:0];
        end
        // read clears status; new events win over the clear
        if (wb_hit && !wb_we_i && wb_adr_i == scs_pkg::ADDR_IRQ_STAT)
        begin
            r_d.irq_stat = ev;
        end
        else
        begin
            r_d.irq_stat = r_q.irq_stat | ev;
        end
        r_d.irq = |(r_d.irq_stat & r_d.irq_mask);
    end

    // state register with synchronous reset and clock enable
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            r_q <= '0;
            r_q.st <= scs_pkg::ST_STRAP;
            r_q.th_cur <= 1'b1;
            r_q.irq_mask <= scs_pkg::IRQ_MASK_RESET;
        end
        else if (ce_i)
        begin
            r_q <= r_d;
        end
    end

    assign wb_dat_o = r_q.rdata;
    assign wb_ack_o = r_q.ack;
    assign gate_enable_o = r_q.gate;
    assign low_power_o = r_q.lowp;
    assign enable_current_low_o = r_q.en_cur_low;
    assign threshold_strap_current_o = r_q.th_cur;
    assign irq_o = r_q.irq;

    // assertions
    property no_drive_lowpow;
        @(posedge clock_i) disable iff (rst_i) r_q.st == scs_pkg::ST_LOWPOW |-> !gate_enable_o;
    endproperty
    low_no_gate_a: assert property (no_drive_lowpow) else $error("gate on in low power"); // [RQ8]
    sequence resume_full;
        r_q.st == scs_pkg::ST_RESUME && !r_q.gate;
    endsequence
    resume_wait_a: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ13]
        $rose(r_q.st == scs_pkg::ST_RESUME) && ce_i |-> resume_full)
        else $error("resume not gated");
    strap_current_a: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ3]
        r_q.st == scs_pkg::ST_RUN |-> !threshold_strap_current_o)
        else $error("strap source left on");
    en_current_a: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ2]
        r_q.st == scs_pkg::ST_RUN |-> enable_current_low_o)
        else $error("enable source not lowered");
    no_autosleep_a: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ7]
        !r_q.sleep_en |-> r_q.conf_cnt == 10'h0)
        else $error("duty count with sleep off");
    strap_restart_a: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ14]
        en_rise && ce_i && r_q.st != scs_pkg::ST_STRAP |=> r_q.st == scs_pkg::ST_STRAP)
        else $error("no strap on enable rise");
    enable_low_a: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ8]
        ce_i && r_q.st == scs_pkg::ST_RUN && !en_now && !en_rise |=> r_q.st == scs_pkg::ST_LOWPOW)
        else $error("enable low not obeyed");
    sleep_latch_a: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ6]
        ce_i && r_q.st == scs_pkg::ST_STRAP && en_now && en_code == scs_pkg::EN_CODE_OPEN
        |=> !r_q.sleep_en)
        else $error("open strap left sleep on");
endmodule : scs_top

// >>> dv/scs_primary_model.sv
`timescale 1ns/1ns
// stand-in for the primary half-bridge: a duty sample every other half cycle while it switches
module scs_primary_model (
    input wire logic clock_i,
    input wire logic run_i, // primary is switching
    input wire logic [6:0] level_i, // duty to report
    output logic [6:0] duty_o = 7'h00,
    output logic duty_valid_o = 1'b0,
    output logic drain_sense_one_o = 1'b1,
    output logic drain_sense_two_o = 1'b1
);
    logic phase_q = 1'b0; // half-cycle phase, one clock per half cycle
    // samples and drain levels follow the phase
    always_ff @(posedge clock_i)
    begin
        phase_q <= ~phase_q;
        duty_valid_o <= run_i & phase_q;
        // outside a sample the old duty is not held, so a stale read cannot pass
        duty_o <= (run_i & phase_q) ? level_i : ~duty_o;
        // halted primary leaves both drains above arming_level
        drain_sense_one_o <= ~run_i | phase_q;
        drain_sense_two_o <= ~run_i | ~phase_q;
    end
endmodule : scs_primary_model

// >>> dv/test_strap_config_sleep_control.sv
`timescale 1ns/1ns
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module test_strap_config_sleep_control;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic enable_pin_i = 1'b0;
    logic [1:0] en_code = 2'h0;
    logic [1:0] th_code = 2'h0;
    logic run = 1'b0; // primary switching
    logic ce = 1'b1; // clock enable to the block
    logic [6:0] level = 7'h00; // duty reported by the primary
    logic [6:0] duty;
    logic duty_valid, sense_one, sense_two;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o, rd;
    logic wb_ack_o, gate, lowp, cur_low, th_cur, irq;
    int fail_count = 0;
    int tests_run = 0;
    // rows: index {enable code, threshold code} beside the exit threshold it must latch
    logic [6:0] exit_tab [0:15] = '{7'h50, 7'h4B, 7'h41, 7'h3C, 7'h4B, 7'h46, 7'h3C, 7'h37,
        7'h50, 7'h4B, 7'h41, 7'h00, 7'h50, 7'h4B, 7'h41, 7'h00};
    logic [6:0] entry_tab [0:1] = '{7'h28, 7'h19};
    // free-running clock, 4 ns period
    always #2 clock_i = ~clock_i;
    scs_top #(.BURST_CYCLES_P(20)) i_scs_top (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce),
        .enable_pin_i(enable_pin_i), .enable_strap_code_i(en_code), .threshold_strap_code_i(th_code),
        .drain_sense_one_i(sense_one), .drain_sense_two_i(sense_two), .duty_i(duty),
        .duty_valid_i(duty_valid), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .gate_enable_o(gate), .low_power_o(lowp), .enable_current_low_o(cur_low),
        .threshold_strap_current_o(th_cur), .irq_o(irq));
    scs_primary_model i_scs_primary_model (.clock_i(clock_i), .run_i(run), .level_i(level),
        .duty_o(duty), .duty_valid_o(duty_valid), .drain_sense_one_o(sense_one),
        .drain_sense_two_o(sense_two));
    // verdict and end of run
    task stop_test;
        $display("counts: %0d compared, %0d mismatched", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    // one classic cycle; request held until ack is sampled, read data taken there
    task wb(input logic we, input logic [3:0] adr, input logic [31:0] wd);
        @(posedge clock_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, adr, wd};
        // no cycle count assumed; only the watchdog ends a hung wait
        do
        begin
            @(posedge clock_i);
        end
        while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        `CHK(wb_ack_o, 1'b1)
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    endtask : wb
    // pull enable low, set straps, raise enable and wait until running
    task strap(input logic [1:0] e, input logic [1:0] t);
        int n;
        @(posedge clock_i);
        {enable_pin_i, en_code, th_code} <= {1'b0, e, t};
        repeat (6) @(posedge clock_i);
        enable_pin_i <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clock_i);
            n++;
        end
        while (!(lowp === 1'b0 && th_cur === 1'b0 && cur_low === 1'b1) && n < 40);
    endtask : strap
    // watchdog well beyond the expected run length
    initial
    begin
        repeat (20000) @(posedge clock_i);
        fail_count++;
        $display("mismatch at %0t: timeout", $time);
        stop_test();
    end
    // main sequence
    initial
    begin
        repeat (12) @(posedge clock_i);
        `CHK({th_cur, gate, lowp, cur_low, irq, wb_ack_o}, 6'h20)
        rst_i <= 1'b0;
        $display("test reset done");
        for (int r = 0; r < 16; r++)
        begin
            strap(r[3:2], r[1:0]);
            `CHK({th_cur, cur_low, gate}, 3'h3)
            wb(1'b0, 4'h0, 32'h0);
            `CHK(rd[6:0], exit_tab[r])
            wb(1'b0, 4'h4, 32'h0);
            `CHK(rd[4], (r < 8) ? 1'b1 : 1'b0)
            if (r < 8) `CHK(rd[22:16], entry_tab[r[2]])
        end
        $display("test strap rows done");
        // sleep enabled: 100k enable, 100k threshold; primary already switching so no burst
        {run, level} <= {1'b1, 7'h50};
        strap(2'h0, 2'h1);
        wb(1'b0, 4'h8, 32'h0);
        `CHK(rd[2], 1'b1)
        wb(1'b1, 4'hC, 32'h1);
        wb(1'b0, 4'h2, 32'h0);
        `CHK(rd, 32'h0)
        {run, level, en_code} <= {1'b1, 7'h27, 2'h1};
        repeat (1000) @(posedge clock_i);
        `CHK({lowp, irq}, 2'h0)
        repeat (100) @(posedge clock_i);
        `CHK({lowp, gate, irq}, 3'h5)
        wb(1'b0, 4'h8, 32'h0);
        `CHK(rd[0], 1'b1)
        repeat (2) @(posedge clock_i);
        `CHK(irq, 1'b0)
        level <= 7'h4B;
        repeat (100) @(posedge clock_i);
        `CHK(lowp, 1'b1)
        wb(1'b0, 4'h0, 32'h0);
        `CHK(rd[6:0], 7'h4B)
        level <= 7'h4C;
        repeat (20) @(posedge clock_i);
        `CHK(gate, 1'b0)
        repeat (30) @(posedge clock_i);
        `CHK(gate, 1'b1)
        $display("test auto sleep done");
        // sleep disabled: open enable, 180k threshold
        strap(2'h2, 2'h2);
        level <= 7'h05;
        repeat (1200) @(posedge clock_i);
        `CHK({lowp, gate}, 2'h1)
        run <= 1'b0;
        repeat (12) @(posedge clock_i);
        `CHK(lowp, 1'b0)
        repeat (20) @(posedge clock_i);
        `CHK({lowp, gate}, 2'h2)
        {run, level} <= {1'b1, 7'h41};
        repeat (100) @(posedge clock_i);
        `CHK(lowp, 1'b1)
        level <= 7'h42;
        repeat (60) @(posedge clock_i);
        `CHK(gate, 1'b1)
        enable_pin_i <= 1'b0;
        repeat (10) @(posedge clock_i);
        `CHK({lowp, gate}, 2'h2)
        // clock enable low: an enable rise must not restart the strap phase
        ce <= 1'b0;
        enable_pin_i <= 1'b1;
        repeat (10) @(posedge clock_i);
        `CHK({lowp, gate, th_cur}, 3'h4)
        ce <= 1'b1;
        $display("test burst and off done");
        stop_test();
    end
endmodule : test_strap_config_sleep_control
